// ==== include/hts_pkg.sv ====
// Shared constants and types for the serial channel and the TDM bus end
// What this block does
// - Data moves only through DMA streams
// - HDLC or transparent; pins or internal bus
// - TDM tri-states line outside slot; full-time drives
// - Slot enable marks slot or enabled transmitter
// - Receiver samples in slot or every bit
// - Eight-entry FIFOs on both paths
// - Transmit on falling, sample on rising edges
// - Slots counted from frame sync rising edge
// - Nonzero length activates the slot assigner, except on internal clock
// - Skip start bits, pass length bits, block
// - Software picks standard subchannel start/length pairs
// - End-of-buffer entry closes frame with CRC if selected, then flag
// - Command entries set last bits and CRC
// - Underrun buffers complete with status in HDLC or with URWAIT set, else none
// - Receiver treats all ready buffers alike
// - Frame end closes receive buffer with status
// - Full buffer without frame end: no status
// - Frame end or overrun: five status bits
// - Rate generator counts down, toggles, reloads later
// - DIGITAL_PLL resyncs on transitions, else divides by 16
// - Software loads sixteen times the bit rate
// - Fill character between frames or after underrun
package hts_pkg;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [7:0] HDLC_FLAG = 8'h7e;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [3:0] RESID_BITS = 4'h6;
  localparam logic [3:0] DIGITAL_PLL_HALF = 4'h7;
  localparam logic [3:0] TX_DIV_LAST = 4'hf;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TDM = 4'h4;
  localparam logic [3:0] REG_RATE = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  // Control bits
  localparam int CTL_TX_SLOT_ENABLE = 0;
  localparam int CTL_RXEN = 1;
  localparam int CTL_TXHDLC = 2;
  localparam int CTL_RXHDLC = 3;
  localparam int CTL_PINS = 4;
  localparam int CTL_INTCLK = 5;
  localparam int CTL_URWAIT = 6;
  localparam int CTL_CRCEN = 7;
  // Receive status code bits
  localparam int ST_EOF = 0;
  localparam int ST_CRCERR = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_RESID = 4;
  // Reset values
  localparam logic [7:0] FILL_RESET = 8'h7e;
  localparam logic [15:0] TCONST_RESET = 16'h0007;
  localparam logic [7:0] BUFLEN_RESET = 8'h10;
  // TDM bus end timing
  localparam logic [7:0] BIT_HALF = 8'h08;
  localparam logic [7:0] FRAME_BITS = 8'h60;

  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CRC, TX_CLOSE} hts_txstate_type;

  typedef struct packed {
    logic cmd;
    logic crc;
    logic [2:0] last;
    logic endBuf;
    logic [7:0] data;
  } hts_txent_type;

  typedef struct packed {
    logic isStat;
    logic [7:0] data;
  } hts_rxent_type;

  function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
    return {1'b0, c[15:1]} ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = crc_step(r, d[i]);
    return r;
  endfunction
endpackage

// ==== include/hts_tdm_if.sv ====
// Internal TDM bus between the serial channel and the TDM bus end
`timescale 1ns/1ns
`default_nettype none
interface hts_tdm_if;
  logic commonBitClock;
  logic frameSync;
  logic rxLine;
  logic txOut;
  logic txOe;
  logic txSlotEnable;
  logic txLine;

  // Tri-state bused line idles high
  assign txLine = txOe ? txOut : 1'b1;

  modport channel(input commonBitClock, frameSync, rxLine, output txOut, txOe, txSlotEnable);
  modport tdm(input txLine, txSlotEnable, output commonBitClock, frameSync, rxLine);
endinterface
`default_nettype wire

// ==== verilog/hts_tdm_end.sv ====
// TDM bus end: makes bit clock and frame sync, streams the lines
`timescale 1ns/1ns
`default_nettype none
module hts_tdm_end
  import hts_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus
  hts_tdm_if.tdm bus,
  // User side
  input wire logic dnBit,
  output logic dnTake,
  output logic upBit,
  output logic upValid,
  output logic frameStart
);
  typedef struct packed {
    logic [7:0] div;
    logic bclk;
    logic [7:0] pos;
    logic fs;
    logic rx;
    logic upBit;
    logic upValid;
    logic dnTake;
    logic frameStart;
  } hts_endstate_type;

  hts_endstate_type s;
  hts_endstate_type n;

  always_comb
  begin
    n = s;
    n.dnTake = 1'b0;
    n.upValid = 1'b0;
    n.frameStart = 1'b0;
    n.div = s.div + 8'h01;
    if (s.div == BIT_HALF - 8'h01)
    begin
      n.div = 8'h00;
      n.bclk = !s.bclk;
      if (s.bclk)
      begin
        // Falling edge: frame sync and data change here
        n.pos = (s.pos == FRAME_BITS - 8'h01) ? 8'h00 : s.pos + 8'h01;
        n.fs = (n.pos == 8'h00);
        n.frameStart = n.fs;
        n.rx = dnBit;
        n.dnTake = 1'b1;
      end
      else if (bus.txSlotEnable)
      begin
        // Rising edge: sample the shared line inside the slot
        n.upBit = bus.txLine;
        n.upValid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.rx <= 1'b1;
    end
    else
      s <= n;
  end

  assign bus.commonBitClock = s.bclk;
  assign bus.frameSync = s.fs;
  assign bus.rxLine = s.rx;
  assign dnTake = s.dnTake;
  assign upBit = s.upBit;
  assign upValid = s.upValid;
  assign frameStart = s.frameStart;
endmodule
`default_nettype wire

// ==== verilog/hts_channel.sv ====
// Serial channel: HDLC or transparent transmitter and receiver
`timescale 1ns/1ns
`default_nettype none
module hts_channel
  import hts_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Internal TDM bus
  hts_tdm_if.channel tdm,
  // Device pins
  input wire logic pinBitClock,
  input wire logic pinFrameSync,
  input wire logic pinRxData,
  output logic pinTxData,
  output logic pinTxOe,
  output logic pinTxSlotEnable,
  // Register bus
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  // Transmit DMA stream
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txEndBuf,
  input wire logic txCmd,
  input wire logic [2:0] txLastBits,
  input wire logic txSendCrc,
  output logic txReady,
  output logic txDone,
  output logic txDoneStatus,
  // Receive DMA stream
  output logic rxValid,
  output logic rxHasData,
  output logic [7:0] rxData,
  output logic rxClose,
  output logic rxWithStatus,
  output logic [4:0] rxCode,
  input wire logic rxReady
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] txStart;
    logic [7:0] txLen;
    logic [7:0] rxStart;
    logic [7:0] rxLen;
    logic [7:0] fill;
    logic [15:0] tconst;
    logic [7:0] bufLen;
    logic avWait;
    logic [31:0] avRd;
    logic bc1, bc2, bc3, fs1, fs2, fs3, rd1, rd2, rdPrev;
    logic [7:0] pos;
    logic [15:0] brgCnt;
    logic brgRl, brgOut;
    logic [3:0] dpCnt, txDiv;
    logic [7:0][13:0] txF;
    logic [2:0] txWp, txRp;
    logic [3:0] txN;
    logic txRdy;
    hts_txstate_type txSt;
    logic [15:0] txSh;
    logic [4:0] txBits;
    logic [2:0] txOnes, txLast;
    logic txStuff, txCrcUpd, txCrcOn, txUr, txMid, txDone, txDoneSt, txOe;
    logic [15:0] txCrc;
    logic lineOut, busOe, pinOe;
    logic [7:0] rxSh, rxRaw;
    logic [3:0] rxBits;
    logic [2:0] rxOnes;
    logic rxIn, rxGot, rxOv;
    logic [15:0] rxCrc;
    logic [7:0][8:0] rxF;
    logic [2:0] rxWp, rxRp;
    logic [3:0] rxN;
    logic [7:0] bufCnt;
    logic rxValid, rxHas, rxClose, rxWs;
    logic [7:0] rxData;
  } hts_chstate_type;

  hts_chstate_type s;
  hts_chstate_type n;

  function automatic logic in_slot(logic [7:0] p, logic [7:0] st, logic [7:0] ln);
    return (ln == 8'h00) || (p >= st && {1'b0, p} < {1'b0, st} + {1'b0, ln});
  endfunction

  always_comb
  begin
    hts_txent_type ent;
    hts_rxent_type pent;
    hts_rxent_type oent;
    logic req, pins, tx_slot_enable, rxEn, hdlcT, hdlcR, intclk, ft;
    logic bcRise, bcFall, brgEdge, txTick, rxTick, b, bi, ins, tPush, tPop, rPush, rPop;
    logic [2:0] lb;
    n = s;
    ent = hts_txent_type'(s.txF[s.txRp]);
    oent = hts_rxent_type'(s.rxF[s.rxRp]);
    pent = '0;
    req = avsRead || avsWrite;
    pins = s.ctrl[CTL_PINS];
    tx_slot_enable = s.ctrl[CTL_TX_SLOT_ENABLE];
    rxEn = s.ctrl[CTL_RXEN];
    hdlcT = s.ctrl[CTL_TXHDLC];
    hdlcR = s.ctrl[CTL_RXHDLC];
    intclk = s.ctrl[CTL_INTCLK];
    ft = (s.txLen == 8'h00) || intclk;
    bcRise = s.bc2 && !s.bc3;
    bcFall = !s.bc2 && s.bc3;
    brgEdge = 1'b0;
    b = s.lineOut;
    bi = s.rd2;
    ins = 1'b0;
    tPop = 1'b0;
    rPush = 1'b0;
    lb = 3'h0;
    tPush = 1'b0;
    txTick = 1'b0;
    rxTick = 1'b0;
    rPop = 1'b0;
    // Register bus: one wait cycle, then a single ready cycle
    n.avWait = !(req && s.avWait);
    if (req && s.avWait)
    begin
      if (avsAddress == REG_CTRL)
        n.avRd = {24'h0, s.ctrl};
      else if (avsAddress == REG_TDM)
        n.avRd = {s.rxLen, s.rxStart, s.txLen, s.txStart};
      else if (avsAddress == REG_RATE)
        n.avRd = {s.tconst, s.bufLen, s.fill};
      else if (avsAddress == REG_STAT)
        n.avRd = {16'h0, s.txN, s.rxN, 3'h0, s.rxIn, s.txUr, s.rxOv, s.txSt};
      else
        n.avRd = 32'h0;
    end
    if (avsWrite && !s.avWait)
    begin
      if (avsAddress == REG_CTRL)
        n.ctrl = avsWriteData[7:0];
      else if (avsAddress == REG_TDM)
        {n.rxLen, n.rxStart, n.txLen, n.txStart} = avsWriteData;
      else if (avsAddress == REG_RATE)
        {n.tconst, n.bufLen, n.fill} = avsWriteData;
    end
    // Input synchronisers
    n.bc1 = pins ? pinBitClock : tdm.commonBitClock;
    n.bc2 = s.bc1;
    n.bc3 = s.bc2;
    n.fs1 = pins ? pinFrameSync : tdm.frameSync;
    n.fs2 = s.fs1;
    n.rd1 = pins ? pinRxData : tdm.rxLine;
    n.rd2 = s.rd1;
    n.rdPrev = s.rd2;
    if (bcRise)
    begin
      n.fs3 = s.fs2;
      if (s.fs2 && !s.fs3)
        n.pos = 8'h00;
      else if (s.pos != 8'hff)
        n.pos = s.pos + 8'h01;
    end
    // Rate generator and DIGITAL_PLL
    if (!(intclk && (tx_slot_enable || rxEn)))
    begin
      n.brgCnt = s.tconst;
      n.brgRl = 1'b0;
    end
    else if (s.brgRl)
    begin
      n.brgCnt = s.tconst;
      n.brgRl = 1'b0;
    end
    else if (s.brgCnt == 16'h0000)
    begin
      n.brgOut = !s.brgOut;
      n.brgRl = 1'b1;
      brgEdge = !s.brgOut;
    end
    else
      n.brgCnt = s.brgCnt - 16'h0001;
    if (s.rd2 != s.rdPrev)
      n.dpCnt = 4'h0;
    else if (brgEdge)
      n.dpCnt = s.dpCnt + 4'h1;
    if (brgEdge)
      n.txDiv = s.txDiv + 4'h1;
    rxTick = rxEn && (intclk ? (brgEdge && s.dpCnt == DIGITAL_PLL_HALF && s.rd2 == s.rdPrev)
      : (bcRise && in_slot(s.pos, s.rxStart, s.rxLen)));
    txTick = tx_slot_enable && (intclk ? (brgEdge && s.txDiv == TX_DIV_LAST)
      : (bcFall && in_slot(s.pos, s.txStart, s.txLen)));
    // Transmit FIFO
    tPush = txValid && s.txRdy;
    if (tPush)
    begin
      n.txF[s.txWp] = {txCmd, txSendCrc, txLastBits, txEndBuf, txData};
      n.txWp = s.txWp + 3'h1;
    end
    // Transmitter
    n.txDone = 1'b0;
    if (!tx_slot_enable)
    begin
      n.txSt = TX_IDLE;
      n.txBits = 5'h00;
      n.txOnes = 3'h0;
      n.txMid = 1'b0;
    end
    else if (txTick)
    begin
      if (s.txBits == 5'h00 && s.txOnes != ONES_STUFF)
      begin
        n.txStuff = 1'b0;
        n.txCrcUpd = 1'b0;
        n.txBits = 5'h08;
        n.txSh = {8'h00, s.fill};
        case (s.txSt)
          TX_IDLE:
            if (s.txN != 4'h0 && hdlcT)
            begin
              n.txSh = {8'h00, HDLC_FLAG};
              n.txSt = TX_DATA;
              n.txCrc = CRC_INIT;
            end
            else if (s.txN != 4'h0)
            begin
              tPop = 1'b1;
              n.txSh = {8'h00, ent.data};
              n.txMid = !ent.endBuf;
            end
            else if (s.txMid && !hdlcT)
              n.txUr = 1'b1;
          TX_DATA:
            if (s.txN == 4'h0)
            begin
              n.txUr = 1'b1;
              n.txSh = {8'h00, HDLC_FLAG};
              n.txSt = TX_IDLE;
            end
            else
            begin
              tPop = 1'b1;
              if (ent.cmd)
              begin
                n.txLast = ent.last;
                n.txCrcOn = ent.crc;
              end
              lb = ent.cmd ? ent.last : s.txLast;
              n.txSh = {8'h00, ent.data};
              n.txStuff = 1'b1;
              n.txCrcUpd = 1'b1;
              if (ent.endBuf)
              begin
                n.txBits = (lb == 3'h0) ? 5'h08 : {2'b00, lb};
                n.txSt = (ent.cmd ? ent.crc : s.txCrcOn) ? TX_CRC : TX_CLOSE;
              end
            end
          TX_CRC:
          begin
            n.txSh = ~s.txCrc;
            n.txBits = 5'h10;
            n.txStuff = 1'b1;
            n.txSt = TX_CLOSE;
          end
          default:
          begin
            n.txSh = {8'h00, HDLC_FLAG};
            n.txSt = TX_IDLE;
          end
        endcase
        if (tPop && ent.endBuf)
        begin
          n.txDone = 1'b1;
          n.txDoneSt = (hdlcT || s.ctrl[CTL_URWAIT]) && n.txUr;
          n.txUr = 1'b0;
        end
      end
      ins = s.txOnes == ONES_STUFF;
      b = ins ? 1'b0 : n.txSh[0];
      if (!ins)
      begin
        n.txSh = {1'b0, n.txSh[15:1]};
        n.txBits = n.txBits - 5'h01;
        if (n.txCrcUpd)
          n.txCrc = crc_step(n.txCrc, b);
      end
      n.txOnes = (n.txStuff && b && !ins) ? s.txOnes + 3'h1 : 3'h0;
      n.lineOut = b;
    end
    if (tPop)
      n.txRp = s.txRp + 3'h1;
    n.txN = s.txN + {3'h0, tPush} - {3'h0, tPop};
    n.txRdy = n.txN != FIFO_FULL;
    if (ft)
      n.txOe = tx_slot_enable;
    else if (bcFall)
      n.txOe = tx_slot_enable && in_slot(s.pos, s.txStart, s.txLen);
    n.busOe = !pins && n.txOe;
    n.pinOe = pins && n.txOe;
    // Receiver
    if (!rxEn)
    begin
      n.rxIn = 1'b0;
      n.rxBits = 4'h0;
      n.rxOnes = 3'h0;
    end
    else if (rxTick && !hdlcR)
    begin
      n.rxSh = {bi, s.rxSh[7:1]};
      n.rxBits = s.rxBits + 4'h1;
      if (s.rxBits == 4'h7)
      begin
        rPush = 1'b1;
        pent = {1'b0, n.rxSh};
        n.rxBits = 4'h0;
      end
    end
    else if (rxTick)
    begin
      n.rxRaw = {bi, s.rxRaw[7:1]};
      if (n.rxRaw == HDLC_FLAG)
      begin
        if (s.rxIn && s.rxGot)
        begin
          rPush = 1'b1;
          pent.isStat = 1'b1;
          pent.data[ST_EOF] = 1'b1;
          pent.data[ST_CRCERR] = s.rxCrc != CRC_GOOD;
          pent.data[ST_RESID] = s.rxBits != RESID_BITS;
        end
        n.rxIn = 1'b1;
        n.rxGot = 1'b0;
        n.rxBits = 4'h0;
        n.rxOnes = 3'h0;
        n.rxCrc = CRC_INIT;
      end
      else if (s.rxOnes == ONES_STUFF && !bi)
        n.rxOnes = 3'h0;
      else if (bi && s.rxOnes >= ONES_STUFF)
      begin
        if (s.rxOnes != 3'h7)
          n.rxOnes = s.rxOnes + 3'h1;
        if (s.rxOnes == 3'h6 && s.rxIn)
        begin
          rPush = s.rxGot;
          pent.isStat = 1'b1;
          pent.data[ST_ABORT] = 1'b1;
          n.rxIn = 1'b0;
        end
      end
      else
      begin
        n.rxOnes = bi ? s.rxOnes + 3'h1 : 3'h0;
        if (s.rxIn)
        begin
          n.rxSh = {bi, s.rxSh[7:1]};
          n.rxBits = s.rxBits + 4'h1;
          if (s.rxBits == 4'h7)
          begin
            rPush = 1'b1;
            pent = {1'b0, n.rxSh};
            n.rxCrc = crc_byte(s.rxCrc, n.rxSh);
            n.rxGot = 1'b1;
            n.rxBits = 4'h0;
          end
        end
      end
    end
    if (rPush && s.rxN == FIFO_FULL)
    begin
      rPush = 1'b0;
      n.rxOv = 1'b1;
      n.rxIn = 1'b0;
    end
    else if (!rPush && s.rxOv && s.rxN != FIFO_FULL)
    begin
      rPush = 1'b1;
      pent = '0;
      pent.isStat = 1'b1;
      pent.data[ST_OVERRUN] = 1'b1;
      n.rxOv = 1'b0;
    end
    if (rPush)
    begin
      n.rxF[s.rxWp] = pent;
      n.rxWp = s.rxWp + 3'h1;
    end
    // Receive output stage and buffer accounting
    rPop = (!s.rxValid || rxReady) && s.rxN != 4'h0;
    if (rPop)
    begin
      n.rxRp = s.rxRp + 3'h1;
      n.rxValid = 1'b1;
      n.rxHas = !oent.isStat;
      n.rxData = oent.data;
      n.rxWs = oent.isStat;
      n.rxClose = oent.isStat || (s.bufCnt + 8'h01 == s.bufLen);
      n.bufCnt = n.rxClose ? 8'h00 : s.bufCnt + 8'h01;
    end
    else if (rxReady)
      n.rxValid = 1'b0;
    n.rxN = s.rxN + {3'h0, rPush} - {3'h0, rPop};
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.avWait <= 1'b1;
      s.fill <= FILL_RESET;
      s.tconst <= TCONST_RESET;
      s.bufLen <= BUFLEN_RESET;
      s.txRdy <= 1'b1;
      s.lineOut <= 1'b1;
      s.rd1 <= 1'b1;
      s.rd2 <= 1'b1;
      s.rdPrev <= 1'b1;
    end
    else
      s <= n;
  end

  assign tdm.txOut = s.lineOut;
  assign tdm.txOe = s.busOe;
  assign tdm.txSlotEnable = s.busOe;
  assign pinTxData = s.lineOut;
  assign pinTxOe = s.pinOe;
  assign pinTxSlotEnable = s.pinOe;
  assign avsReadData = s.avRd;
  assign avsWaitrequest = s.avWait;
  assign txReady = s.txRdy;
  assign txDone = s.txDone;
  assign txDoneStatus = s.txDoneSt;
  assign rxValid = s.rxValid;
  assign rxHasData = s.rxHas;
  assign rxData = s.rxData;
  assign rxClose = s.rxClose;
  assign rxWithStatus = s.rxWs;
  assign rxCode = s.rxData[4:0];
endmodule
`default_nettype wire

// ==== dv/hts_tdm_checker.sv ====
// Checker for the internal TDM bus between the channel and the bus end
`timescale 1ns/1ns
`default_nettype none
module hts_tdm_checker
  import hts_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // TDM bus signals
  input wire logic commonBitClock,
  input wire logic frameSync,
  input wire logic rxLine,
  input wire logic txOut,
  input wire logic txOe,
  input wire logic txSlotEnable,
  input wire logic txLine
);
  logic clkPrev_q;
  logic syncPrev_q;
  logic syncSeen_q;
  int sinceFall_q;
  int bitCnt_q;

  // Cycles since the bit clock fell, and bit clock rises per frame
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clkPrev_q <= 1'b0;
      syncPrev_q <= 1'b0;
      syncSeen_q <= 1'b0;
      sinceFall_q <= 15;
      bitCnt_q <= 0;
    end
    else
    begin
      clkPrev_q <= commonBitClock;
      syncPrev_q <= frameSync;
      if (clkPrev_q && !commonBitClock)
        sinceFall_q <= 0;
      else if (sinceFall_q < 15)
        sinceFall_q <= sinceFall_q + 1;
      if (frameSync && !syncPrev_q)
      begin
        bitCnt_q <= (commonBitClock && !clkPrev_q) ? 1 : 0;
        syncSeen_q <= 1'b1;
      end
      else if (commonBitClock && !clkPrev_q)
        bitCnt_q <= bitCnt_q + 1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence highPhase;
    commonBitClock [*8] ##1 !commonBitClock;
  endsequence
  sequence lowPhase;
    !commonBitClock [*8] ##1 commonBitClock;
  endsequence

  slot_marks_drive_a: assert property (txSlotEnable == txOe)
    else $error("Slot enable differs from line drive");
  line_idle_a: assert property (!txOe |-> txLine)
    else $error("Released line not high");
  tx_on_fall_a: assert property (($changed(txOut) && txOe && $past(txOe)) |-> sinceFall_q <= 6)
    else $error("Transmit bit changed away from a falling edge");
  drive_on_fall_a: assert property ($changed(txOe) |-> sinceFall_q <= 6)
    else $error("Line drive changed away from a falling edge");
  rx_in_low_a: assert property ($changed(rxLine) |-> !commonBitClock)
    else $error("Receive line changed while bit clock high");
  clk_high_a: assert property ($rose(commonBitClock) |-> highPhase)
    else $error("Bit clock high phase wrong");
  clk_low_a: assert property ($fell(commonBitClock) |-> lowPhase)
    else $error("Bit clock low phase wrong");
  frame_bits_a: assert property (($rose(frameSync) && syncSeen_q) |-> bitCnt_q == FRAME_BITS)
    else $error("Frame length in bits wrong");
  sync_width_a: assert property ($rose(frameSync) |-> frameSync [*8])
    else $error("Frame sync shorter than a bit");
  slot_width_a: assert property ($rose(txSlotEnable) |-> txSlotEnable [*8])
    else $error("Slot shorter than a bit");
endmodule
`default_nettype wire

// ==== dv/hts_channel_tb.sv ====
// Self-checking bench: channel and TDM bus end joined by the bus
`timescale 1ns/1ns
`default_nettype none
module hts_channel_tb
  import hts_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWaitrequest;
  logic txValid = 1'b0;
  logic [7:0] txData = 8'h0;
  logic txEndBuf = 1'b0;
  logic txCmd = 1'b0;
  logic txReady, txDone, txDoneStatus;
  logic rxValid, rxHasData, rxClose, rxWithStatus;
  logic [7:0] rxData;
  logic [4:0] rxCode;
  logic rxReady = 1'b0;
  logic dnBit = 1'b1;
  logic dnTake, upBit, upValid, frameStart;
  logic pinTxOe, pinTxSlotEnable;
  logic [31:0] patShift_q = 32'h0;
  logic patSeen_q = 1'b0;
  logic dnQ[$];
  logic [10:0] rxQ[$];
  int n_errors = 0;
  int samples_checked = 0;

  hts_tdm_if tdmBus();
  hts_tdm_end hts_tdm_end_inst(.clk_sys(clk_sys), .rst_b(rst_b), .bus(tdmBus.tdm),
    .dnBit(dnBit), .dnTake(dnTake), .upBit(upBit), .upValid(upValid), .frameStart(frameStart));
  hts_channel hts_channel_inst(.clk_sys(clk_sys), .rst_b(rst_b), .tdm(tdmBus.channel),
    .pinBitClock(1'b0), .pinFrameSync(1'b0), .pinRxData(1'b1), .pinTxData(), .pinTxOe(pinTxOe),
    .pinTxSlotEnable(pinTxSlotEnable), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
    .txValid(txValid), .txData(txData), .txEndBuf(txEndBuf), .txCmd(txCmd),
    .txLastBits(3'h0), .txSendCrc(1'b0), .txReady(txReady), .txDone(txDone),
    .txDoneStatus(txDoneStatus), .rxValid(rxValid), .rxHasData(rxHasData), .rxData(rxData),
    .rxClose(rxClose), .rxWithStatus(rxWithStatus), .rxCode(rxCode), .rxReady(rxReady));
  hts_tdm_checker hts_tdm_checker_inst(.clk_sys(clk_sys), .rst_b(rst_b),
    .commonBitClock(tdmBus.commonBitClock), .frameSync(tdmBus.frameSync),
    .rxLine(tdmBus.rxLine), .txOut(tdmBus.txOut), .txOe(tdmBus.txOe),
    .txSlotEnable(tdmBus.txSlotEnable), .txLine(tdmBus.txLine));

  always #4 clk_sys = ~clk_sys;

  // Receive taker stalls every other cycle; line feeder and line watcher
  always @(posedge clk_sys)
  begin
    rxReady <= ~rxReady;
    if (rxValid && rxReady)
      rxQ.push_back({rxHasData, rxClose, rxWithStatus, rxHasData ? rxData : {3'h0, rxCode}});
    if (dnTake)
      dnBit <= (dnQ.size() > 0) ? dnQ.pop_front() : 1'b1;
    if (upValid)
      patShift_q <= {upBit, patShift_q[31:1]};
    if (patShift_q === {HDLC_FLAG, 8'h13, 8'h12, HDLC_FLAG})
      patSeen_q <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do
      @(posedge clk_sys);
    while (avsWaitrequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic push_run(input int cnt, input logic [7:0] base, input logic close);
    txValid <= 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      txData <= base + i[7:0];
      txEndBuf <= close && (i == cnt - 1);
      txCmd <= (i == 0);
      do
        @(posedge clk_sys);
      while (txReady !== 1'b1);
    end
    txValid <= 1'b0;
    txCmd <= 1'b0;
  endtask

  task automatic wait_done(output logic st);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (txDone !== 1'b1 && n < 30000);
    st = txDoneStatus;
    check(txDone, 1'b1, "done pulse");
  endtask

  task automatic wait_frames(input int k);
    repeat (k)
      do
        @(posedge clk_sys);
      while (frameStart !== 1'b1);
  endtask

  task automatic test_regs();
    logic [31:0] q;
    avs(0, REG_CTRL, 32'h0, q);
    check(q, 32'h0, "control reset");
    avs(0, REG_TDM, 32'h0, q);
    check(q, 32'h0, "slot reset");
    avs(0, REG_RATE, 32'h0, q);
    check(q, {TCONST_RESET, BUFLEN_RESET, FILL_RESET}, "rate reset");
    avs(1, REG_STAT, 32'hffff_ffff, q);
    avs(0, REG_STAT, 32'h0, q);
    check(q, 32'h0, "status read only");
    avs(1, 4'h2, 32'hffff_ffff, q);
    avs(0, 4'h2, 32'h0, q);
    check(q, 32'h0, "unmapped place");
    avs(1, REG_RATE, 32'h0123_027e, q);
    avs(0, REG_RATE, 32'h0, q);
    check(q, 32'h0123_027e, "rate write");
    $display("test_regs done");
  endtask

  task automatic test_hdlc_tx();
    logic [31:0] q;
    logic st;
    int cnt;
    wait_frames(1);
    avs(1, REG_TDM, 32'h0000_0808, q);
    avs(1, REG_CTRL, 32'h0000_0005, q);
    push_run(2, 8'h12, 1'b1);
    wait_done(st);
    check(st, 1'b0, "frame done status");
    cnt = 0;
    while (patSeen_q !== 1'b1 && cnt < 10000)
    begin
      @(posedge clk_sys);
      cnt++;
    end
    check(patSeen_q, 1'b1, "flagged frame on line");
    wait_frames(1);
    cnt = 0;
    do
    begin
      @(posedge clk_sys);
      cnt += (upValid === 1'b1);
    end
    while (frameStart !== 1'b1);
    check(cnt, 8, "slot bits per frame");
    $display("test_hdlc_tx done");
  endtask

  task automatic test_underrun();
    logic [31:0] q;
    logic st;
    for (int uw = 1; uw >= 0; uw--)
    begin
      wait_frames(1);
      avs(1, REG_CTRL, (uw != 0) ? 32'h41 : 32'h01, q);
      push_run(FIFO_DEPTH, 8'h40, 1'b0);
      @(posedge clk_sys);
      check(txReady, 1'b0, "ready with eight held");
      avs(0, REG_STAT, 32'h0, q);
      check(q[15:12], 4'h8, "eight entries held");
      wait_frames(FIFO_DEPTH + 2);
      push_run(1, 8'h5a, 1'b1);
      wait_done(st);
      check(st, uw[0], "underrun done status");
    end
    $display("test_underrun done");
  endtask

  task automatic test_rx();
    logic [31:0] q;
    logic [7:0] bytes[4];
    int n;
    bytes = '{HDLC_FLAG, 8'h12, 8'h34, HDLC_FLAG};
    avs(1, REG_CTRL, 32'h0000_000b, q);
    foreach (bytes[i])
      for (int b = 0; b < 8; b++)
        dnQ.push_back(bytes[i][b]);
    n = 0;
    while (rxQ.size() < 3 && n < 5000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check(rxQ[0], {3'b100, 8'h12}, "first byte");
    check(rxQ[1], {3'b110, 8'h34}, "full buffer closes plain");
    check(rxQ[2], {3'b011, 8'h03}, "frame end status");
    $display("test_rx done");
  endtask

  task automatic test_intclk();
    logic [31:0] q;
    logic st;
    avs(1, REG_CTRL, 32'h0, q);
    wait_frames(1);
    avs(1, REG_RATE, 32'h0003_027e, q);
    avs(1, REG_CTRL, 32'h0000_0031, q);
    push_run(1, 8'ha5, 1'b1);
    check(pinTxOe, 1'b1, "full-time pin drive");
    check(pinTxSlotEnable, 1'b1, "full-time slot enable");
    wait_done(st);
    check(st, 1'b0, "rate clocked done status");
    $display("test_intclk done");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    test_regs();
    test_hdlc_tx();
    test_underrun();
    test_rx();
    test_intclk();
    end_sim();
  end

  initial
  begin
    repeat (95000) @(posedge clk_sys);
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
